// >>> hdl/pll_status_pkg.sv
package pll_status_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_LOCK_STATUS = 8'hc4;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hc5;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'hc6;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'hc8;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'hc9;
  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h80;
  localparam logic [7:0] EVENT_MASK_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Status bit positions
  localparam int BIT_CLK_READY = 7;
  localparam int BIT_RF_HI = 6;
  localparam int BIT_RF_LO = 5;
  localparam int BIT_IF_HI = 4;
  localparam int BIT_IF_LO = 3;
  localparam int BIT_BOTH_LOCK = 2;
  localparam int BIT_IF_LOCK = 1;
  localparam int BIT_RF_LOCK = 0;
  localparam int NUM_DOMAINS = 4;
  // Power-ready settle delay
  localparam int POWER_DELAY_NS = 15000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_DELAY_CYC =
    (POWER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_CNT_W = 11;
  localparam logic [PWR_CNT_W-1:0] PWR_CNT_ZERO = '0;
  localparam logic [PWR_CNT_W-1:0] PWR_CNT_ONE = 11'h001;
endpackage : pll_status_pkg

// >>> hdl/pll_status_interrupt_logic.sv
// Strobed register access was decided locally.
module pll_status_interrupt_logic
  import pll_status_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_clk_ready,
  input wire logic i_rf_tune_hi,
  input wire logic i_rf_tune_lo,
  input wire logic i_if_tune_hi,
  input wire logic i_if_tune_lo,
  input wire logic i_if_lock,
  input wire logic i_rf_lock,
  input wire logic i_if_pll_en,
  input wire logic i_rf_pll_en,
  input wire logic [3:0] i_domain_en,
  input wire logic [3:0] i_bandgap_ok,
  output logic o_interrupt_out_n,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops per asynchronous input
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  // Pin bundle, most significant first
  assign raw_in = {
    i_bandgap_ok,
    i_if_pll_en,
    i_rf_pll_en,
    i_clk_ready,
    i_rf_tune_hi,
    i_rf_tune_lo,
    i_if_tune_hi,
    i_if_tune_lo,
    i_if_lock,
    i_rf_lock
  };

  // Two-stage synchroniser chain
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // Synchronised levels; nothing reads the first stage
  logic [3:0] bandgap_s;
  logic if_en_s;
  logic rf_en_s;
  logic clk_rdy_s;
  logic rf_hi_s;
  logic rf_lo_s;
  logic if_hi_s;
  logic if_lo_s;
  logic if_lock_s;
  logic rf_lock_s;

  // Unpack in the same order as the pin bundle
  assign {
    bandgap_s,
    if_en_s,
    rf_en_s,
    clk_rdy_s,
    rf_hi_s,
    rf_lo_s,
    if_hi_s,
    if_lo_s,
    if_lock_s,
    rf_lock_s
  } = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // One-cycle strobes per register
  logic wr_enable;
  logic wr_mask;
  logic wr_evt;
  logic rd_status;
  assign wr_enable = i_wr && hit(i_addr, ADDR_IRQ_ENABLE);
  assign wr_mask = i_wr && hit(i_addr, ADDR_EVENT_MASK);
  assign wr_evt = i_wr && hit(i_addr, ADDR_EVENT_STATUS);
  assign rd_status = i_rd && hit(i_addr, ADDR_LOCK_STATUS);

  // Reference clock alive only while a PLL is enabled
  logic ref_on;
  assign ref_on = if_en_s || rf_en_s;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable register, write only
  logic [7:0] irq_en_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_en_q <= IRQ_ENABLE_RST;
    end else if (wr_enable) begin
      irq_en_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live conditions and previous-cycle copies
  logic [7:0] live;
  logic [7:0] live_prev_q;
  logic [7:0] event_now;

  // Live view of every status source
  always_comb begin
    live = ZERO8;
    live[BIT_CLK_READY] = clk_rdy_s;
    live[BIT_RF_HI] = rf_hi_s;
    live[BIT_RF_LO] = rf_lo_s;
    live[BIT_IF_HI] = if_hi_s;
    live[BIT_IF_LO] = if_lo_s;
    live[BIT_BOTH_LOCK] = if_lock_s && rf_lock_s;
    live[BIT_IF_LOCK] = if_lock_s;
    live[BIT_RF_LOCK] = rf_lock_s;
  end

  // Previous levels for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      live_prev_q <= ZERO8;
    end else begin
      live_prev_q <= live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level drop between the previous and the current cycle
  function automatic logic went_low(input logic prev, input logic now);
    went_low = prev && !now;
  endfunction : went_low

  // Lock-loss edges, shared by the single and combined bits
  logic if_lock_fall;
  logic rf_lock_fall;
  logic lock_both_fall;
  assign if_lock_fall =
    went_low(live_prev_q[BIT_IF_LOCK], live[BIT_IF_LOCK]);
  assign rf_lock_fall =
    went_low(live_prev_q[BIT_RF_LOCK], live[BIT_RF_LOCK]);
  assign lock_both_fall = if_lock_fall || rf_lock_fall;

  // Per-bit event: rise for bits 7..3, fall for lock bits
  always_comb begin
    event_now = live & ~live_prev_q;
    event_now[BIT_BOTH_LOCK] = lock_both_fall;
    event_now[BIT_IF_LOCK] = if_lock_fall;
    event_now[BIT_RF_LOCK] = rf_lock_fall;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched status bits; event set wins over read clear
  logic [7:0] latch_q;
  // Shared index for the per-bit and per-domain loops
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_latch
      // Clock loss or enable off empties the bit; set beats read
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          latch_q[gi] <= 1'b0;
        end else if (!ref_on || !irq_en_q[gi]) begin
          latch_q[gi] <= 1'b0;
        end else if (event_now[gi]) begin
          latch_q[gi] <= 1'b1;
        end else if (rd_status) begin
          latch_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Visible status: live when disabled, latched when enabled
  logic [7:0] live_part;
  logic [7:0] held_part;
  logic [7:0] status_view;
  assign live_part = live & ~irq_en_q;
  assign held_part = latch_q & irq_en_q;
  assign status_view = ref_on ? (live_part | held_part) : ZERO8;

  ////////////////////////////////////////////////////////////////////////////
  // Power-ready delay per domain; dropping the enable restarts it
  logic [3:0] pwr_ready_q;
  generate
    for (gi = 0; gi < NUM_DOMAINS; gi++) begin : g_pwr
      logic [PWR_CNT_W-1:0] cnt_q;
      logic settled;
      // Settled once the count has reached the full delay
      assign settled = (cnt_q == POWER_DELAY_CYC[PWR_CNT_W-1:0]);
      // Count while enabled, then follow the supply-good level
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          cnt_q <= PWR_CNT_ZERO;
          pwr_ready_q[gi] <= 1'b0;
        end else if (!i_domain_en[gi]) begin
          cnt_q <= PWR_CNT_ZERO;
          pwr_ready_q[gi] <= 1'b0;
        end else if (!settled) begin
          cnt_q <= cnt_q + PWR_CNT_ONE;
          pwr_ready_q[gi] <= 1'b0;
        end else begin
          pwr_ready_q[gi] <= bandgap_s[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event status for the system interrupt, write one to clear
  logic [7:0] evt_q;
  logic [7:0] mask_q;
  logic [7:0] evt_clr;
  logic [7:0] evt_set;

  // Clear mask from the write, new events while the clock runs
  assign evt_clr = wr_evt ? i_wdata : ZERO8;
  assign evt_set = ref_on ? event_now : ZERO8;

  // Sticky event bits; a new event wins over a clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evt_q <= ZERO8;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // Event mask register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_q <= EVENT_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux for the addressed register; write-only reads zero
  logic [7:0] rd_value;
  always_comb begin
    rd_value = ZERO8;
    case (i_addr)
      ADDR_LOCK_STATUS: rd_value = status_view;
      ADDR_POWER_STATUS: rd_value = {4'h0, pwr_ready_q};
      ADDR_EVENT_STATUS: rd_value = evt_q;
      ADDR_EVENT_MASK: rd_value = mask_q;
      default: rd_value = ZERO8;
    endcase
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= ZERO8;
    end else if (i_rd) begin
      o_rdata <= rd_value;
    end else begin
      o_rdata <= ZERO8;
    end
  end

  // Interrupt outputs
  logic [7:0] irq_pending;
  assign irq_pending = latch_q & irq_en_q;
  assign o_interrupt_out_n = ~|irq_pending;
  assign o_irq = |(evt_q & mask_q);

endmodule : pll_status_interrupt_logic

// >>> dv/host_irq_model.sv
module host_irq_model (
  input wire logic i_clk,
  input wire logic i_irq_n,
  output logic o_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host samples the interrupt line
  always_ff @(posedge i_clk) o_hit <= !i_irq_n;
endmodule : host_irq_model

// >>> dv/pll_status_asserts.sv
module pll_status_asserts
  import pll_status_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_rf_lock,
  input wire logic i_if_lock,
  input wire logic i_if_pll_en,
  input wire logic i_rf_pll_en,
  input wire logic o_interrupt_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en_q;
  wire logic rs = i_rd && i_addr == ADDR_LOCK_STATUS;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow of the write-only enable register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) en_q <= IRQ_ENABLE_RST;
    else if (i_wr && i_addr == ADDR_IRQ_ENABLE) en_q <= i_wdata;
  end
  // Read data, interrupt pin
  AST_EN_READ_ZERO: assert property (
    i_rd && i_addr == ADDR_IRQ_ENABLE |=> o_rdata == ZERO8) else $error("en");
  AST_RSVD_ZERO: assert property (
    i_rd && i_addr == ADDR_POWER_STATUS |=> o_rdata[7:4] == 4'h0)
    else $error("rsvd");
  AST_IRQ_AFTER_RESET: assert property (
    $rose(i_rst_n) |-> o_interrupt_out_n) else $error("rst irq");
  AST_LIVE_RF: assert property (
    (!en_q[0] && i_rf_lock && i_rf_pll_en)[*5] ##0 rs |=> o_rdata[0])
    else $error("live");
  AST_LATCH_RF: assert property (
    i_rf_lock[*4] ##1 (!i_rf_lock && en_q[0] && i_rf_pll_en)
    |-> ##[1:6] !o_interrupt_out_n) else $error("latch");
  AST_NOPLL_IRQ: assert property (
    (!i_if_pll_en && !i_rf_pll_en)[*5] |-> o_interrupt_out_n)
    else $error("nopll");
  AST_EN_OFF: assert property (
    (en_q == ZERO8)[*2] |-> o_interrupt_out_n) else $error("enoff");
  AST_READ_CLEARS: assert property (
    (en_q[7:3] == 5'h00 && $stable(i_rf_lock) && $stable(i_if_lock) &&
     i_rf_pll_en)[*6] ##0 rs |=> o_interrupt_out_n) else $error("clr");
endmodule : pll_status_asserts

bind pll_status_interrupt_logic pll_status_asserts u_chk (.i_clk, .i_rst_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rf_lock, .i_if_lock,
  .i_if_pll_en,
  .i_rf_pll_en, .o_interrupt_out_n);

// >>> dv/test_pll_status_interrupt_logic.sv
module test_pll_status_interrupt_logic;
  import pll_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_clk_ready = 0;
  logic i_rf_tune_hi = 0, i_rf_tune_lo = 1, i_if_tune_hi = 0;
  logic i_if_tune_lo = 1, i_if_lock = 1, i_rf_lock = 1, i_if_pll_en = 1;
  logic i_rf_pll_en = 1, o_interrupt_out_n, o_irq, hit;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
  logic [3:0] i_domain_en = 0, i_bandgap_ok = 4'h5;
  int fail_count = 0, n_compared = 0, ticks = 0;
  pll_status_interrupt_logic u_dut (.i_clk, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_clk_ready, .i_rf_tune_hi, .i_rf_tune_lo,
    .i_if_tune_hi, .i_if_tune_lo, .i_if_lock, .i_rf_lock, .i_if_pll_en,
    .i_rf_pll_en, .i_domain_en, .i_bandgap_ok, .o_interrupt_out_n, .o_irq);
  host_irq_model u_host (.i_clk, .i_irq_n(o_interrupt_out_n), .o_hit(hit));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    ticks++;
    if (ticks == 6000) begin
      fail_count++;
      summarize();
    end
  end
  task summarize;
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task fl(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask : fl
  // Bus cycles
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    @(posedge i_clk);
    chk(o_rdata, e);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_live;
    rd(ADDR_IRQ_ENABLE, ZERO8);
    rd(ADDR_POWER_STATUS, ZERO8);
    fl(o_interrupt_out_n, 1'h1);
    i_clk_ready <= 1'h1;
    repeat (6) @(posedge i_clk);
    fl(o_interrupt_out_n, 1'h0);
    rd(ADDR_LOCK_STATUS, 8'haf);
    fl(o_interrupt_out_n, 1'h1);
    wr(ADDR_IRQ_ENABLE, ZERO8);
    i_if_tune_hi <= 1'h1;
    repeat (6) @(posedge i_clk);
    rd(ADDR_LOCK_STATUS, 8'hbf);
    i_rf_lock <= 1'h0;
    i_if_tune_hi <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(ADDR_LOCK_STATUS, 8'haa);
    i_rf_lock <= 1'h1;
  endtask : t_live
  task t_latch;
    wr(ADDR_EVENT_STATUS, 8'hff);
    wr(ADDR_EVENT_MASK, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h07);
    i_if_lock <= 1'h0;
    repeat (6) @(posedge i_clk);
    fl(o_interrupt_out_n, 1'h0);
    fl(hit, 1'h1);
    fl(o_irq, 1'h1);
    rd(ADDR_LOCK_STATUS, 8'hae);
    rd(ADDR_LOCK_STATUS, 8'ha8);
    fl(o_interrupt_out_n, 1'h1);
    rd(ADDR_EVENT_STATUS, 8'h06);
    wr(ADDR_EVENT_STATUS, 8'h06);
    repeat (2) @(posedge i_clk);
    fl(o_irq, 1'h0);
    i_if_lock <= 1'h1;
    i_rf_lock <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(ADDR_LOCK_STATUS, 8'had);
    i_rf_lock <= 1'h1;
    wr(ADDR_IRQ_ENABLE, 8'h08);
    i_if_tune_lo <= 1'h0;
    repeat (6) @(posedge i_clk);
    i_if_tune_lo <= 1'h1;
    repeat (6) @(posedge i_clk);
    i_if_tune_lo <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(ADDR_LOCK_STATUS, 8'haf);
  endtask : t_latch
  task t_nopll;
    i_if_pll_en <= 1'h0;
    i_rf_pll_en <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(ADDR_LOCK_STATUS, ZERO8);
    i_domain_en <= 4'hf;
    repeat (1400) @(posedge i_clk);
    rd(ADDR_POWER_STATUS, ZERO8);
    repeat (200) @(posedge i_clk);
    rd(ADDR_POWER_STATUS, 8'h05);
  endtask : t_nopll
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_live();
    t_latch();
    t_nopll();
    summarize();
  end
endmodule : test_pll_status_interrupt_logic
